// >>> mrmdp_pkg.sv
// Summary of operation
// - Management data line is shared; each side releases it when the other drives.
// - MII transmit clock runs 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; the code divides the 10 MHz core clock to 5 MHz and 500 kHz.
// - RMII leaves both MII clocks idle; reference clock times both directions.
// - MII receive clock runs 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; the code gives 5 MHz and 500 kHz, the same as the transmit clock.
// - MII receive nibbles follow the receive clock, valid only with data valid.
// - Receive data valid is high exactly while a valid nibble is presented.
// - RMII gives a receive data valid independent of carrier sense.
// - MII at 100 Mb/s flags receive error on an invalid symbol in a packet.
// - RMII at 100 Mb/s flags receive error on media error during data valid.
// - Device corrupts delivered data on any receive error.
// - RMII receive data is two bits per reference clock.
// - MII carrier sense is high while the receive medium is busy.
// - RMII merges carrier and receive data valid into one signal.
// - Half duplex: collision high while transmit and receive overlap; the code holds col low in RMII.
// - 10 Mb/s half duplex heartbeat pulses collision for about 1 us after transmit; the code gives no heartbeat in RMII.
// - Full duplex holds collision low and gives no heartbeat.
package mrmdp_pkg;

    localparam int CORE_CLK_NS    = 100;
    localparam int MDC_MAX_MHZ    = 25;
    localparam int MII_FAST_KHZ   = 25000;
    localparam int MII_SLOW_KHZ   = 2500;
    localparam int SLOW_RATIO     = MII_FAST_KHZ / MII_SLOW_KHZ;
    localparam int HB_TIME_NS     = 1000;
    localparam int HB_CYCLES      = (HB_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

    localparam int          DIV_W      = 5;
    localparam logic [4:0]  HALF_FAST  = 5'h01;
    localparam logic [4:0]  HALF_SLOW  = 5'(SLOW_RATIO);
    localparam int          HB_W       = 4;
    localparam logic [3:0]  HB_LOAD    = 4'(HB_CYCLES);

    localparam int          FIFO_DEPTH = 16;
    localparam int          RXW_W      = 5;
    localparam int          RXW_ERR    = 4;
    localparam logic [3:0]  CORRUPT    = 4'h5;

    localparam int          PRE_BITS   = 32;
    localparam logic [5:0]  PRE_LAST   = 6'h1f;
    localparam logic [1:0]  OP_READ    = 2'h2;
    localparam logic [1:0]  OP_WRITE   = 2'h1;
    localparam logic [4:0]  ADDR_LAST  = 5'h04;
    localparam logic [4:0]  DATA_LAST  = 5'h0f;
    localparam logic [4:0]  OP_LAST    = 5'h01;
    localparam logic [4:0]  TA_LAST    = 5'h01;

    typedef enum logic [6:0] {
        MG_PRE  = 7'h01,
        MG_ST   = 7'h02,
        MG_OP   = 7'h04,
        MG_PA   = 7'h08,
        MG_RA   = 7'h10,
        MG_TA   = 7'h20,
        MG_DAT  = 7'h40
    } mrmdp_mg_state_t;

endpackage

// >>> mrmdp_stream_if.sv
`timescale 1ns/1ps
interface mrmdp_stream_if #(
    parameter int W = 5
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> mrmdp_fifo.sv
`timescale 1ns/1ps
module mrmdp_fifo #(
    parameter int W     = 5,
    parameter int DEPTH = 16
) (
    input wire logic        clk,
    input wire logic        rst_n,
    mrmdp_stream_if.snk     in_s,
    mrmdp_stream_if.src     out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    assign in_s.ready  = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data  = mem[rd_ptr];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// >>> mrmdp_mgmt.sv
`timescale 1ns/1ps
module mrmdp_mgmt (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mdc_s,
    input  wire logic        mdio_s,
    input  wire logic [4:0]  phy_addr,
    output logic             mdio_o,
    output logic             mdio_oe,
    output logic             mgmt_wr,
    output logic [4:0]       mgmt_reg_addr,
    output logic [15:0]      mgmt_wr_data,
    input  wire logic [15:0] mgmt_rd_data
);
    mrmdp_pkg::mrmdp_mg_state_t state;
    logic        mdc_q;
    logic        rise;
    logic        fall;
    logic [5:0]  ones;
    logic [4:0]  cnt;
    logic [1:0]  op;
    logic [4:0]  pa;
    logic [15:0] shreg;
    logic        is_rd;
    logic        hit;

    // Edges of the already synchronised clock; 10 MHz core limits usable rate
    assign rise = mdc_s && !mdc_q;
    assign fall = !mdc_s && mdc_q;
    assign hit  = (pa == phy_addr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_q <= 1'b0;
        end else begin
            mdc_q <= mdc_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= mrmdp_pkg::MG_PRE;
            ones          <= '0;
            cnt           <= '0;
            op            <= '0;
            pa            <= '0;
            shreg         <= '0;
            is_rd         <= 1'b0;
            mgmt_wr       <= 1'b0;
            mgmt_reg_addr <= '0;
            mgmt_wr_data  <= '0;
        end else begin
            mgmt_wr <= 1'b0;
            if (rise) begin
                case (state)
                    mrmdp_pkg::MG_PRE: begin
                        if (mdio_s) begin
                            ones <= (ones == mrmdp_pkg::PRE_LAST + 6'h01) ? ones : ones + 6'h01;
                        end else begin
                            if (ones > mrmdp_pkg::PRE_LAST) begin
                                state <= mrmdp_pkg::MG_ST;
                            end
                            ones <= '0;
                        end
                    end
                    mrmdp_pkg::MG_ST: begin
                        state <= mdio_s ? mrmdp_pkg::MG_OP : mrmdp_pkg::MG_PRE;
                        cnt   <= '0;
                    end
                    mrmdp_pkg::MG_OP: begin
                        op  <= {op[0], mdio_s};
                        cnt <= cnt + 5'h01;
                        if (cnt == mrmdp_pkg::OP_LAST) begin
                            state <= mrmdp_pkg::MG_PA;
                            cnt   <= '0;
                        end
                    end
                    mrmdp_pkg::MG_PA: begin
                        pa  <= {pa[3:0], mdio_s};
                        cnt <= cnt + 5'h01;
                        if (cnt == mrmdp_pkg::ADDR_LAST) begin
                            state <= mrmdp_pkg::MG_RA;
                            cnt   <= '0;
                        end
                    end
                    mrmdp_pkg::MG_RA: begin
                        mgmt_reg_addr <= {mgmt_reg_addr[3:0], mdio_s};
                        cnt           <= cnt + 5'h01;
                        if (cnt == mrmdp_pkg::ADDR_LAST) begin
                            state <= mrmdp_pkg::MG_TA;
                            cnt   <= '0;
                            is_rd <= hit && (op == mrmdp_pkg::OP_READ);
                        end
                    end
                    mrmdp_pkg::MG_TA: begin
                        cnt <= cnt + 5'h01;
                        if (cnt == mrmdp_pkg::TA_LAST) begin
                            state <= mrmdp_pkg::MG_DAT;
                            cnt   <= '0;
                            shreg <= mgmt_rd_data;
                        end
                    end
                    mrmdp_pkg::MG_DAT: begin
                        cnt <= cnt + 5'h01;
                        if (!is_rd) begin
                            shreg <= {shreg[14:0], mdio_s};
                        end else begin
                            shreg <= {shreg[14:0], 1'b0};
                        end
                        if (cnt == mrmdp_pkg::DATA_LAST) begin
                            state <= mrmdp_pkg::MG_PRE;
                            is_rd <= 1'b0;
                            if (hit && op == mrmdp_pkg::OP_WRITE) begin
                                mgmt_wr      <= 1'b1;
                                mgmt_wr_data <= {shreg[14:0], mdio_s};
                            end
                        end
                    end
                    default: state <= mrmdp_pkg::MG_PRE;
                endcase
            end
        end
    end

    // Drive on falling edges so the manager samples a settled bit on rising
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (fall) begin
            if (is_rd && state == mrmdp_pkg::MG_TA && cnt == mrmdp_pkg::TA_LAST) begin
                mdio_oe <= 1'b1;
                mdio_o  <= 1'b0;
            end else if (is_rd && state == mrmdp_pkg::MG_DAT) begin
                mdio_oe <= 1'b1;
                mdio_o  <= shreg[15];
            end else begin
                mdio_oe <= 1'b0;
                mdio_o  <= 1'b0;
            end
        end
    end
endmodule

// >>> mrmdp_top.sv
`timescale 1ns/1ps
module mrmdp_top #(
    parameter int FIFO_DEPTH = mrmdp_pkg::FIFO_DEPTH
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        rmii_mode,
    input  wire logic        speed_100,
    input  wire logic        full_duplex,
    input  wire logic        heartbeat_en,
    input  wire logic [4:0]  phy_addr,
    input  wire logic        line_rx_valid,
    input  wire logic [3:0]  line_rx_data,
    input  wire logic        line_rx_err,
    input  wire logic        line_carrier,
    output logic             line_rx_ready,
    output logic             line_tx_valid,
    output logic [3:0]       line_tx_data,
    input  wire logic        tx_en,
    input  wire logic [3:0]  txd,
    output logic             tx_clk,
    output logic             rx_clk,
    output logic             rx_dv,
    output logic             rx_er,
    output logic [3:0]       rxd,
    output logic             crs,
    output logic             col,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe,
    output logic             mgmt_wr,
    output logic [4:0]       mgmt_reg_addr,
    output logic [15:0]      mgmt_wr_data,
    input  wire logic [15:0] mgmt_rd_data
);
    logic                    rst_m;
    logic                    rst_core_n;
    logic [4:0]              tx_sync1;
    logic [4:0]              tx_sync2;
    logic [1:0]              mg_sync1;
    logic [1:0]              mg_sync2;
    logic [mrmdp_pkg::DIV_W-1:0] div_cnt;
    logic [mrmdp_pkg::DIV_W-1:0] next_div;
    logic [mrmdp_pkg::DIV_W-1:0] half;
    logic                    mii_clk;
    logic                    tick;
    logic                    rphase;
    logic [1:0]              rhold;
    logic [3:0]              rnib;
    logic                    tphase;
    logic [1:0]              tlow;
    logic                    tx_act;
    logic                    tx_act_q;
    logic [mrmdp_pkg::HB_W-1:0] hb_cnt;

    mrmdp_stream_if #(.W(mrmdp_pkg::RXW_W)) rx_in ();
    mrmdp_stream_if #(.W(mrmdp_pkg::RXW_W)) rx_out ();

    // Corrupted nibble replaces the payload so a MAC may ignore rx_er
    function automatic logic [3:0] deliver(input logic [mrmdp_pkg::RXW_W-1:0] w);
        deliver = w[mrmdp_pkg::RXW_ERR] ? mrmdp_pkg::CORRUPT : w[3:0];
    endfunction

    assign rnib = deliver(rx_out.data);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m      <= 1'b0;
            rst_core_n <= 1'b0;
        end else begin
            rst_m      <= 1'b1;
            rst_core_n <= rst_m;
        end
    end

    // Pins from the MAC and the manager are asynchronous to core_clk
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            tx_sync1 <= '0;
            tx_sync2 <= '0;
            mg_sync1 <= '0;
            mg_sync2 <= '0;
        end else begin
            tx_sync1 <= {tx_en, txd};
            tx_sync2 <= tx_sync1;
            mg_sync1 <= {mdc, mdio_i};
            mg_sync2 <= mg_sync1;
        end
    end

    assign tx_act = tx_sync2[4];

    // One divider serves both MII clocks; recovered timing is not modelled
    assign half = speed_100 ? mrmdp_pkg::HALF_FAST : mrmdp_pkg::HALF_SLOW;

    always_comb begin
        if (rmii_mode || div_cnt >= ((half << 1) - 5'h01)) begin
            next_div = '0;
        end else begin
            next_div = div_cnt + 5'h01;
        end
    end

    assign tick = rmii_mode || (div_cnt == half - 5'h01);

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            div_cnt <= '0;
            mii_clk <= 1'b0;
        end else begin
            div_cnt <= next_div;
            mii_clk <= !rmii_mode && (next_div < half);
        end
    end

    assign tx_clk = mii_clk;
    assign rx_clk = mii_clk;

    assign rx_in.valid   = line_rx_valid;
    assign rx_in.data    = {line_rx_err, line_rx_data};
    assign line_rx_ready = rx_in.ready;

    mrmdp_fifo #(
        .W     (mrmdp_pkg::RXW_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk   (core_clk),
        .rst_n (rst_core_n),
        .in_s  (rx_in),
        .out_s (rx_out)
    );

    // A nibble leaves the buffer per MII tick, or per dibit pair in RMII
    assign rx_out.ready = tick && (!rmii_mode || !rphase);

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            rx_dv  <= 1'b0;
            rx_er  <= 1'b0;
            rxd    <= '0;
            rphase <= 1'b0;
            rhold  <= '0;
        end else if (tick) begin
            if (!rmii_mode) begin
                rphase <= 1'b0;
                rx_dv  <= rx_out.valid;
                rxd    <= rx_out.valid ? deliver(rx_out.data) : 4'h0;
                rx_er  <= rx_out.valid && rx_out.data[mrmdp_pkg::RXW_ERR] && speed_100;
            end else if (!rphase) begin
                if (rx_out.valid) begin
                    rxd    <= {2'h0, rnib[1:0]};
                    rhold  <= rnib[3:2];
                    rphase <= 1'b1;
                    rx_dv  <= 1'b1;
                    rx_er  <= rx_out.data[mrmdp_pkg::RXW_ERR] && speed_100;
                end else begin
                    rxd   <= 4'h0;
                    rx_dv <= 1'b0;
                    rx_er <= 1'b0;
                end
            end else begin
                rxd    <= {2'h0, rhold};
                rphase <= 1'b0;
            end
        end
    end

    // After carrier drops, the merged signal toggles while buffered data drains
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            crs <= 1'b0;
        end else if (!rmii_mode) begin
            crs <= line_carrier;
        end else begin
            crs <= line_carrier || (rx_out.valid && !rphase);
        end
    end

    // Transmit capture: nibbles on ticks in MII, dibit pairs low first in RMII
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            line_tx_valid <= 1'b0;
            line_tx_data  <= '0;
            tphase        <= 1'b0;
            tlow          <= '0;
        end else begin
            line_tx_valid <= 1'b0;
            if (!tx_act) begin
                tphase <= 1'b0;
            end else if (rmii_mode) begin
                if (!tphase) begin
                    tlow   <= tx_sync2[1:0];
                    tphase <= 1'b1;
                end else begin
                    line_tx_valid <= 1'b1;
                    line_tx_data  <= {tx_sync2[1:0], tlow};
                    tphase        <= 1'b0;
                end
            end else if (tick) begin
                line_tx_valid <= 1'b1;
                line_tx_data  <= tx_sync2[3:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            tx_act_q <= 1'b0;
            hb_cnt   <= '0;
        end else begin
            tx_act_q <= tx_act;
            if (tx_act_q && !tx_act && !speed_100 && !full_duplex && heartbeat_en && !rmii_mode) begin
                hb_cnt <= mrmdp_pkg::HB_LOAD;
            end else if (hb_cnt != '0) begin
                hb_cnt <= hb_cnt - 4'h1;
            end
        end
    end

    // RMII has no collision pin function; the MAC works it out itself
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            col <= 1'b0;
        end else if (full_duplex || rmii_mode) begin
            col <= 1'b0;
        end else begin
            col <= (tx_act && line_carrier) || (hb_cnt != '0);
        end
    end

    mrmdp_mgmt u_mgmt (
        .clk           (core_clk),
        .rst_n         (rst_core_n),
        .mdc_s         (mg_sync2[1]),
        .mdio_s        (mg_sync2[0]),
        .phy_addr      (phy_addr),
        .mdio_o        (mdio_o),
        .mdio_oe       (mdio_oe),
        .mgmt_wr       (mgmt_wr),
        .mgmt_reg_addr (mgmt_reg_addr),
        .mgmt_wr_data  (mgmt_wr_data),
        .mgmt_rd_data  (mgmt_rd_data)
    );
endmodule

// >>> mrmdp_top_asserts.sv
`timescale 1ns/1ps
module mrmdp_top_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       rmii_mode,
    input wire logic       speed_100,
    input wire logic       full_duplex,
    input wire logic       line_carrier,
    input wire logic       line_tx_valid,
    input wire logic       tx_clk,
    input wire logic       rx_clk,
    input wire logic       rx_dv,
    input wire logic       rx_er,
    input wire logic [3:0] rxd,
    input wire logic       crs,
    input wire logic       col,
    input wire logic       mgmt_wr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_clk_twins: assert property (tx_clk == rx_clk) else $error("mii clocks differ");
    a_fast_clk: assert property (!rmii_mode && speed_100 && $past(speed_100) && tx_clk |=> !tx_clk)
        else $error("fast clock not toggling");
    a_slow_clk: assert property (!rmii_mode && !speed_100 && $rose(tx_clk) |-> tx_clk[*8] ##3 !tx_clk)
        else $error("slow clock high phase wrong");
    a_rmii_idle: assert property (rmii_mode && $past(rmii_mode) |-> !tx_clk && !rx_clk && rxd[3:2] == 2'h0)
        else $error("rmii clocks or upper data active");
    a_err_corrupt: assert property (rx_er && !rmii_mode |-> rx_dv && rxd == mrmdp_pkg::CORRUPT)
        else $error("error nibble not corrupted");
    a_err_speed: assert property (rx_er |-> speed_100) else $error("receive error at low speed");
    a_mii_crs: assert property (!rmii_mode && $past(!rmii_mode) |-> crs == $past(line_carrier))
        else $error("carrier sense does not follow medium");
    a_full_col: assert property (full_duplex && $past(full_duplex) |-> !col) else $error("collision in full duplex");
    a_rmii_col: assert property (rmii_mode && $past(rmii_mode) |-> !col) else $error("collision in rmii");
    a_hb_len: assert property (!rmii_mode && !full_duplex && !speed_100 && !line_carrier && $rose(col)
        |-> col[*8] ##3 !col) else $error("heartbeat length wrong");
    a_tx_pulse: assert property (line_tx_valid |=> !line_tx_valid) else $error("tx valid not a pulse");
    a_wr_pulse: assert property (mgmt_wr |=> !mgmt_wr) else $error("write strobe not a pulse");
endmodule

bind mrmdp_top mrmdp_top_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .rmii_mode(rmii_mode),
    .speed_100(speed_100), .full_duplex(full_duplex), .line_carrier(line_carrier), .line_tx_valid(line_tx_valid),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs(crs), .col(col),
    .mgmt_wr(mgmt_wr));

// >>> mrmdp_mac_model.sv
`timescale 1ns/1ps
module mrmdp_mac_model (
    input wire logic  clk,
    input wire logic  mdio_o,
    input wire logic  mdio_oe,
    output logic       tx_en,
    output logic [3:0] txd,
    output logic       mdc,
    output logic       mdio_i
);
    logic mgr_o = 1'b1;
    logic mgr_oe = 1'b0;

    // Pull-up wins when nobody drives
    assign mdio_i = mdio_oe ? mdio_o : (mgr_oe ? mgr_o : 1'b1);
    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
        mdc = 1'b0;
    end

    task automatic tx(input logic [15:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            tx_en <= 1'b1;
            txd <= seq[4*(i%4)+:4];
        end
        @(posedge clk);
        tx_en <= 1'b0;
        txd <= ~txd;
    endtask

    // Halves of 8 core cycles keep the synchronised mdc edges well apart
    task automatic mframe(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                          input logic [15:0] wd, output logic [17:0] rd);
        logic [63:0] f;
        f = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk);
            mdc <= 1'b0;
            mgr_o <= f[i];
            mgr_oe <= !((op == 2'h2) && (i < 18));
            repeat (8) @(posedge clk);
            mdc <= 1'b1;
            rd = {rd[16:0], mdio_i};
            repeat (7) @(posedge clk);
        end
        @(posedge clk);
        mdc <= 1'b0;
        mgr_oe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// >>> tb_mii_rmii_mac_data_port.sv
`timescale 1ns/1ps
module tb_mii_rmii_mac_data_port;
    logic core_clk = 0, rst_n = 0, rmii_mode = 0, speed_100 = 1, full_duplex = 0, heartbeat_en = 1;
    logic [4:0] phy_addr = 5'h0b;
    logic line_rx_valid = 0, line_rx_err = 0, line_carrier = 0, line_rx_ready, line_tx_valid;
    logic [3:0] line_rx_data = 4'h0, line_tx_data, txd, rxd;
    logic tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col, mdc, mdio_i, mdio_o, mdio_oe, mgmt_wr, rx_clk_q = 0;
    logic [4:0] mgmt_reg_addr;
    logic [15:0] mgmt_wr_data;
    logic [15:0] mgmt_rd_data = 16'hc3a5;
    int n_fail = 0, total_checks = 0, n_col = 0, cyc = 0;
    logic [3:0] txq[$];
    logic [4:0] rxq[$];
    logic [1:0] rmq[$];
    logic [20:0] wrq[$];

    mrmdp_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .rmii_mode(rmii_mode), .speed_100(speed_100),
        .full_duplex(full_duplex), .heartbeat_en(heartbeat_en), .phy_addr(phy_addr), .line_rx_valid(line_rx_valid),
        .line_rx_data(line_rx_data), .line_rx_err(line_rx_err), .line_carrier(line_carrier),
        .line_rx_ready(line_rx_ready), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .tx_en(tx_en),
        .txd(txd), .tx_clk(tx_clk), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .crs(crs),
        .col(col), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mgmt_wr(mgmt_wr),
        .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wr_data(mgmt_wr_data), .mgmt_rd_data(mgmt_rd_data));
    mrmdp_mac_model u_mac (.clk(core_clk), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .tx_en(tx_en), .txd(txd),
        .mdc(mdc), .mdio_i(mdio_i));

    always #50 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rx_clk_q <= rx_clk;
        if (col === 1'b1) n_col <= n_col + 1;
        if (line_tx_valid === 1'b1) txq.push_back(line_tx_data);
        if (rx_dv === 1'b1 && rx_clk && !rx_clk_q) rxq.push_back({rx_er, rxd});
        if (rx_dv === 1'b1 && rmii_mode) rmq.push_back(rxd[1:0]);
        if (mgmt_wr === 1'b1) wrq.push_back({mgmt_reg_addr, mgmt_wr_data});
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Holds the word until an edge with ready high takes it
    task automatic rx_push(input logic [3:0] d, input logic e);
        line_rx_valid <= 1'b1;
        line_rx_data <= d;
        line_rx_err <= e;
        #1;
        while (line_rx_ready !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
    endtask

    task automatic t_mgmt;
        logic [17:0] rd;
        u_mac.mframe(2'h1, 5'h0b, 5'h07, 16'h1234, rd);
        u_mac.mframe(2'h1, 5'h0c, 5'h03, 16'hffff, rd);
        u_mac.mframe(2'h2, 5'h0b, 5'h02, 16'h0000, rd);
        check("mgmt read", {14'h0, rd}, {14'h0, 2'b10, 16'hc3a5});
        u_mac.mframe(2'h2, 5'h0c, 5'h02, 16'h0000, rd);
        check("foreign read", {14'h0, rd}, 32'h0003_ffff);
        check("write count", 32'(wrq.size()), 32'h1);
        check("write", {11'h0, wrq[0]}, {11'h0, 5'h07, 16'h1234});
    endtask

    task automatic t_rx100;
        rx_push(4'h3, 1'b0);
        rx_push(4'h9, 1'b1);
        line_rx_valid <= 1'b0;
        line_rx_err <= 1'b0;
        repeat (20) @(posedge core_clk);
        check("rx count", 32'(rxq.size()), 32'h2);
        check("rx word", {27'h0, rxq[0]}, 32'h3);
        check("rx error", {27'h0, rxq[1]}, {27'h0, 1'b1, mrmdp_pkg::CORRUPT});
    endtask

    task automatic t_col100;
        txq.delete();
        line_carrier <= 1'b1;
        n_col = 0;
        u_mac.tx(16'haaaa, 6);
        repeat (4) @(posedge core_clk);
        check("carrier", {31'h0, crs}, 32'h1);
        line_carrier <= 1'b0;
        check("collision", 32'(n_col != 0), 32'h1);
        check("tx pulses", 32'(txq.size() >= 2), 32'h1);
        foreach (txq[i]) check("tx nibble", {28'h0, txq[i]}, 32'ha);
    endtask

    task automatic t_rmii;
        @(posedge core_clk);
        txq.delete();
        rmii_mode <= 1'b1;
        line_carrier <= 1'b1;
        u_mac.tx(16'h0312, 5);
        rx_push(4'hd, 1'b0);
        line_rx_valid <= 1'b0;
        repeat (6) @(posedge core_clk);
        check("crs dv", {31'h0, crs}, 32'h1);
        line_carrier <= 1'b0;
        check("rmii tx count", 32'(txq.size()), 32'h2);
        check("rmii tx a", {28'h0, txq[0]}, 32'h6);
        check("rmii tx b", {28'h0, txq[1]}, 32'h3);
        check("rmii rx", {28'h0, rmq[0], rmq[1]}, 32'h7);
        rmii_mode <= 1'b0;
    endtask

    task automatic t_fifo10;
        rxq.delete();
        speed_100 <= 1'b0;
        for (int i = 0; i < 17; i++) rx_push(i[3:0], 1'b0);
        #1;
        check("fifo full", {31'h0, line_rx_ready}, 32'h0);
        line_rx_valid <= 1'b0;
        repeat (400) @(posedge core_clk);
        check("fifo count", 32'(rxq.size()), 32'd17);
        foreach (rxq[i]) check("fifo word", {27'h0, rxq[i]}, {27'h0, 1'b0, 4'(i)});
    endtask

    task automatic t_hb;
        n_col = 0;
        u_mac.tx(16'h0000, 25);
        repeat (30) @(posedge core_clk);
        check("heartbeat", n_col, mrmdp_pkg::HB_CYCLES);
        full_duplex <= 1'b1;
        line_carrier <= 1'b1;
        n_col = 0;
        u_mac.tx(16'h0000, 25);
        repeat (30) @(posedge core_clk);
        check("full duplex col", n_col, 32'h0);
        full_duplex <= 1'b0;
        line_carrier <= 1'b0;
        heartbeat_en <= 1'b0;
        n_col = 0;
        u_mac.tx(16'h0000, 25);
        repeat (30) @(posedge core_clk);
        check("heartbeat off", n_col, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        t_mgmt();
        t_rx100();
        t_col100();
        t_rmii();
        t_fifo10();
        t_hb();
        results();
    end
endmodule
